// File: pbce_gpio.sv
// Purpose: Port B and shared third port GPIO logic with APB register access.
// Assumes: Pins and comparator outputs are asynchronous and pass two flip-flops.
// Notes: The third port variant is fixed at build time by a parameter.
// Notes on behaviour
// - Port B direction per bit, reset zero.
// - Output pins driven; reads return latch.
// - Pull-down off on every output pin.
// - Port B input bits read pin level.
// - Halt rising edge on enabled pin wakes.
// - Wake loads program counter with vector.
// - Output-only variant: four latched outputs.
// - Input-only variant: four inputs with pull-down.
// - Bidir variant: per-bit direction, reset zero.
// - Bidir pull-down only on input pins.
// - Options select amplifier or comparator structure.
// - Bit-1 read-zero option forces bit 1 when comparator 1 enabled.
// - Bit-3 read-zero option forces bit 3 when comparator 2 enabled.
// - Amplifier option enables single amplifier mode unless comparator 1 alone is also on.
// - Each comparator enabled by own option, except in single amplifier mode.
// - Comparator 1 output reads on bit 0.
// - Comparator 2 output reads on bit 2.
// - Comparator-plus-amplifier reads bits 2,3 zero.
`timescale 1ns/10ps
`include "pbce_params.svh"
module pbce_gpio #(
   parameter logic [1:0] VARIANT = `PBCE_VARIANT_BIDIR
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic halt_in,
   input wire logic [3:0] wake_enable_in,
   input wire logic [3:0] pb_pulldown_opt_in,
   input wire logic [3:0] third_pulldown_opt_in,
   input wire logic [3:0] pb_pin_in,
   output logic [3:0] pb_pin_out,
   output logic [3:0] pb_pin_oe_out,
   output logic [3:0] pb_pulldown_out,
   input wire logic [3:0] third_pin_in,
   output logic [3:0] third_pin_out,
   output logic [3:0] third_pin_oe_out,
   output logic [3:0] third_pulldown_out,
   input wire logic [1:0] cmp_result_in,
   output logic amp_enable_out,
   output logic [1:0] cmp_enable_out,
   output logic wake_out,
   output logic [12:0] wake_pc_out
);
   pbce_pkg::pbce_state_s st;
   pbce_pkg::pbce_state_s next_st;
   logic [3:0] pb_meta;
   logic [3:0] third_meta;
   logic [1:0] cmp_meta;
   pbce_pkg::pbce_mode_e mode;
   logic [9:0] idx;
   logic access;
   logic mapped;
   logic [3:0] third_read;
   logic [3:0] pb_read;

   // Only the second stage of each synchroniser feeds logic.
   always_ff @(posedge clk_in) begin
      pb_meta <= pb_pin_in;
      third_meta <= third_pin_in;
      cmp_meta <= cmp_result_in;
   end

   assign idx = paddr_in[11:2];
   assign access = psel_in && penable_in && !st.pready;

   always_comb begin
      mode = pbce_pkg::PBCE_MODE_PLAIN;
      if (st.options[`PBCE_OPT_AMP] && st.options[`PBCE_OPT_CMP1] && !st.options[`PBCE_OPT_CMP2]) begin
         mode = pbce_pkg::PBCE_MODE_CMP_AMP;
      end else if (st.options[`PBCE_OPT_AMP]) begin
         mode = pbce_pkg::PBCE_MODE_AMP;
      end else if (st.options[`PBCE_OPT_CMP1] || st.options[`PBCE_OPT_CMP2]) begin
         mode = pbce_pkg::PBCE_MODE_DUAL_CMP;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pb_read[i] = st.pb_dir[i] ? st.pb_latch[i] : st.pb_in[i];
      end
      third_read = st.third_in;
      if (VARIANT == `PBCE_VARIANT_BIDIR) begin
         for (int i = 0; i < 4; i++) begin
            if (st.third_dir[i]) begin
               third_read[i] = st.third_latch[i];
            end
         end
      end else if (VARIANT == `PBCE_VARIANT_OUT) begin
         third_read = st.third_latch;
      end
      if (VARIANT != `PBCE_VARIANT_OUT) begin
         if (st.options[`PBCE_OPT_CMP1] && mode != pbce_pkg::PBCE_MODE_AMP) begin
            third_read[0] = st.cmp_in[0];
            if (st.options[`PBCE_OPT_BIT1_READ_ZERO]) begin
               third_read[1] = 1'b0;
            end
         end
         if (mode == pbce_pkg::PBCE_MODE_CMP_AMP) begin
            third_read[3:2] = 2'h0;
         end else if (st.options[`PBCE_OPT_CMP2] && mode == pbce_pkg::PBCE_MODE_DUAL_CMP) begin
            third_read[2] = st.cmp_in[1];
            if (st.options[`PBCE_OPT_BIT3_READ_ZERO]) begin
               third_read[3] = 1'b0;
            end
         end
      end
   end

   always_comb begin
      mapped = 1'b1;
      next_st = st;
      next_st.pb_in = pb_meta;
      next_st.third_in = third_meta;
      next_st.cmp_in = cmp_meta;
      next_st.pb_prev = st.pb_in;
      next_st.pready = access;
      next_st.pslverr = 1'b0;
      unique case (idx)
         10'(`PBCE_IDX_PB_DIR): begin
            next_st.prdata = {28'h0000000, st.pb_dir};
            if (access && pwrite_in) begin
               next_st.pb_dir = pwdata_in[3:0];
            end
         end
         10'(`PBCE_IDX_PB_DATA): begin
            next_st.prdata = {28'h0000000, pb_read};
            if (access && pwrite_in) begin
               next_st.pb_latch = pwdata_in[3:0];
            end
         end
         10'(`PBCE_IDX_THIRD_DATA): begin
            mapped = (VARIANT != `PBCE_VARIANT_IN);
            next_st.prdata = {28'h0000000, third_read};
            if (access && pwrite_in && mapped) begin
               next_st.third_latch = pwdata_in[3:0];
            end
         end
         10'(`PBCE_IDX_THIRD_DIR): begin
            mapped = (VARIANT == `PBCE_VARIANT_BIDIR);
            next_st.prdata = {28'h0000000, st.third_dir};
            if (access && pwrite_in && mapped) begin
               next_st.third_dir = pwdata_in[3:0];
            end
         end
         10'(`PBCE_IDX_THIRD_IN): begin
            mapped = (VARIANT == `PBCE_VARIANT_IN);
            next_st.prdata = {28'h0000000, third_read};
         end
         10'(`PBCE_IDX_OPTIONS): begin
            next_st.prdata = {24'h000000, st.options};
            if (access && pwrite_in) begin
               next_st.options = pwdata_in[7:0];
               if (pwdata_in[`PBCE_OPT_AMP]) begin
                  next_st.options[`PBCE_OPT_GAIN] = 1'b0;
               end
            end
         end
         10'(`PBCE_IDX_STATUS): begin
            next_st.prdata = {26'h0, mode, st.wake_seen, st.cmp_in, 1'b0};
            if (access && pwrite_in && pwdata_in[3]) begin
               next_st.wake_seen = 1'b0;
            end
         end
         default: begin
            mapped = 1'b0;
            next_st.prdata = 32'h00000000;
         end
      endcase
      if (!mapped) begin
         next_st.prdata = 32'h00000000;
         next_st.pslverr = access;
      end
      // A wake edge in the clearing cycle still sets the sticky flag.
      next_st.wake = halt_in && |(st.pb_in & ~st.pb_prev & wake_enable_in);
      if (next_st.wake) begin
         next_st.wake_pc = `PBCE_WAKE_VECTOR;
         next_st.wake_seen = 1'b1;
      end
      next_st.pb_out = st.pb_latch;
      next_st.pb_oe = st.pb_dir;
      next_st.pb_pd = pb_pulldown_opt_in & ~st.pb_dir;
      next_st.third_out = st.third_latch;
      unique case (VARIANT)
         `PBCE_VARIANT_OUT: begin
            next_st.third_oe = 4'hF;
            next_st.third_pd = 4'h0;
         end
         `PBCE_VARIANT_IN: begin
            next_st.third_oe = 4'h0;
            next_st.third_pd = third_pulldown_opt_in;
         end
         default: begin
            next_st.third_oe = st.third_dir;
            next_st.third_pd = third_pulldown_opt_in & ~st.third_dir;
         end
      endcase
      next_st.amp_on = (mode == pbce_pkg::PBCE_MODE_AMP) || (mode == pbce_pkg::PBCE_MODE_CMP_AMP);
      next_st.cmp_on = {st.options[`PBCE_OPT_CMP2] && mode == pbce_pkg::PBCE_MODE_DUAL_CMP,
                        st.options[`PBCE_OPT_CMP1] && mode != pbce_pkg::PBCE_MODE_AMP};
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st <= '0;
         st.pb_dir <= `PBCE_RESET_DIR;
         st.third_dir <= `PBCE_RESET_DIR;
         st.pb_latch <= `PBCE_RESET_DATA;
         st.third_latch <= `PBCE_RESET_DATA;
         st.options <= `PBCE_RESET_OPTIONS;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_out = st.prdata;
   assign pready_out = st.pready;
   assign pslverr_out = st.pslverr;
   assign pb_pin_out = st.pb_out;
   assign pb_pin_oe_out = st.pb_oe;
   assign pb_pulldown_out = st.pb_pd;
   assign third_pin_out = st.third_out;
   assign third_pin_oe_out = st.third_oe;
   assign third_pulldown_out = st.third_pd;
   assign amp_enable_out = st.amp_on;
   assign cmp_enable_out = st.cmp_on;
   assign wake_out = st.wake;
   assign wake_pc_out = st.wake_pc;

   // The pull-down and direction outputs lag the register by one cycle.
   chk_pulldown_off_output: assert property (@(posedge clk_in) disable iff (rst_in)
      (pb_pin_oe_out & pb_pulldown_out) == 4'h0) else $error("Pull-down on while Port B drives.");
   chk_bidir_pulldown_input: assert property (@(posedge clk_in) disable iff (rst_in)
      (VARIANT == `PBCE_VARIANT_BIDIR) |-> (third_pin_oe_out & third_pulldown_out) == 4'h0)
      else $error("Third port pull-down on an output.");
   chk_dir_follows_reg: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 pb_pin_oe_out == $past(st.pb_dir)) else $error("Port B enable does not track direction.");
   sequence s_wake_edge;
      halt_in && |(st.pb_in & ~st.pb_prev & wake_enable_in);
   endsequence
   chk_wake_edge_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wake_edge |=> wake_out) else $error("Wake edge missed.");
   chk_wake_vector_load: assert property (@(posedge clk_in) disable iff (rst_in)
      wake_out |-> wake_pc_out == `PBCE_WAKE_VECTOR) else $error("Wake vector wrong.");
   chk_no_wake_awake: assert property (@(posedge clk_in) disable iff (rst_in)
      !$past(halt_in) |-> !wake_out) else $error("Wake outside halt.");
   chk_read_latch_out: assert property (@(posedge clk_in) disable iff (rst_in)
      (access && !pwrite_in && idx == 10'(`PBCE_IDX_PB_DATA) && st.pb_dir == 4'hF)
      |=> prdata_out[3:0] == $past(st.pb_latch)) else $error("Output read is not the latch.");
   chk_read_pin_in: assert property (@(posedge clk_in) disable iff (rst_in)
      (access && idx == 10'(`PBCE_IDX_PB_DATA) && st.pb_dir == 4'h0)
      |=> prdata_out[3:0] == $past(st.pb_in)) else $error("Input read is not the pin.");
   chk_cmp_amp_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      (VARIANT != `PBCE_VARIANT_OUT && mode == pbce_pkg::PBCE_MODE_CMP_AMP) |-> third_read[3:2] == 2'h0)
      else $error("Bits 2 and 3 not zero.");
   chk_shared_addr_variant: assert property (@(posedge clk_in) disable iff (rst_in)
      (VARIANT == `PBCE_VARIANT_IN && access && idx == 10'(`PBCE_IDX_THIRD_DATA)) |=> pslverr_out)
      else $error("Unselected variant answered.");
   chk_input_idx_refused: assert property (@(posedge clk_in) disable iff (rst_in)
      (VARIANT != `PBCE_VARIANT_IN && access && idx == 10'(`PBCE_IDX_THIRD_IN))
      |=> pslverr_out && prdata_out == 32'h00000000) else $error("Input-only index answered.");

   // A taken access is answered with one pready pulse; a master that holds its request is served again two cycles after it was taken.
   sequence s_apb_taken;
      access;
   endsequence
   sequence s_apb_answer;
      pready_out ##1 !pready_out;
   endsequence
   chk_apb_single_ready: assert property (@(posedge clk_in) disable iff (rst_in)
      s_apb_taken |=> s_apb_answer) else $error("Ready is not a single pulse.");

   // Register writes land at the edge after the access is taken.
   chk_pb_dir_write: assert property (@(posedge clk_in) disable iff (rst_in)
      (access && pwrite_in && idx == 10'(`PBCE_IDX_PB_DIR))
      |=> st.pb_dir == $past(pwdata_in[3:0])) else $error("Port B direction write lost.");
   chk_latch_write_input: assert property (@(posedge clk_in) disable iff (rst_in)
      (access && pwrite_in && idx == 10'(`PBCE_IDX_PB_DATA))
      |=> st.pb_latch == $past(pwdata_in[3:0])) else $error("Port B latch write lost.");
   chk_third_dir_write: assert property (@(posedge clk_in) disable iff (rst_in)
      (VARIANT == `PBCE_VARIANT_BIDIR && access && pwrite_in && idx == 10'(`PBCE_IDX_THIRD_DIR))
      |=> st.third_dir == $past(pwdata_in[3:0])) else $error("Third port direction write lost.");

   // Pin outputs lag the latch by one cycle so that every output comes from a flip-flop.
   chk_pb_out_follows: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 pb_pin_out == $past(st.pb_latch)) else $error("Port B output does not track latch.");
   chk_third_out_only: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 (VARIANT != `PBCE_VARIANT_OUT || third_pin_oe_out == 4'hF)) else $error("Output-only pin not driven.");
   chk_input_only_pd: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 (VARIANT != `PBCE_VARIANT_IN || third_pulldown_out == $past(third_pulldown_opt_in)))
      else $error("Input-only pull-down not applied.");
   chk_gain_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
      st.options[`PBCE_OPT_AMP] |-> !st.options[`PBCE_OPT_GAIN]) else $error("Gain on with amplifier.");
   chk_amp_enable_out: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 amp_enable_out == $past(st.options[`PBCE_OPT_AMP])) else $error("Amplifier enable wrong.");

   // Third-port reads are checked on the returned data, not on the read mux itself.
   sequence s_third_read;
      access && !pwrite_in && idx == 10'(`PBCE_IDX_THIRD_DATA) && VARIANT != `PBCE_VARIANT_OUT;
   endsequence
   chk_bit1_read_zero_reads_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      s_third_read ##0 (st.options[`PBCE_OPT_CMP1] && mode != pbce_pkg::PBCE_MODE_AMP
      && st.options[`PBCE_OPT_BIT1_READ_ZERO] && !st.third_dir[1]) |=> prdata_out[1] == 1'b0)
      else $error("Bit 1 not read as zero.");
   chk_cmp1_reads: assert property (@(posedge clk_in) disable iff (rst_in)
      s_third_read ##0 (st.options[`PBCE_OPT_CMP1] && mode != pbce_pkg::PBCE_MODE_AMP)
      |=> prdata_out[0] == $past(st.cmp_in[0])) else $error("Bit 0 not comparator 1.");
   chk_cmp2_reads: assert property (@(posedge clk_in) disable iff (rst_in)
      s_third_read ##0 (st.options[`PBCE_OPT_CMP2] && mode == pbce_pkg::PBCE_MODE_DUAL_CMP)
      |=> prdata_out[2] == $past(st.cmp_in[1])) else $error("Bit 2 not comparator 2.");

   // The sticky flag must catch every wake edge, even one that meets a clearing write.
   chk_wake_seen_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wake_edge |=> st.wake_seen) else $error("Wake flag not set.");
endmodule // pbce_gpio

// File: pbce_params.svh
// Purpose: Offsets, reset values and field positions for the Port B / third port block.
// Assumes: APB byte addresses are four times the printed register index.
// Notes: Included by the package and the design.
`ifndef PBCE_PARAMS_SVH
`define PBCE_PARAMS_SVH
`define PBCE_IDX_THIRD_DIR 8'h01
`define PBCE_IDX_THIRD_DATA 8'h04
`define PBCE_IDX_PB_DIR 8'h05
`define PBCE_IDX_PB_DATA 8'h06
`define PBCE_IDX_THIRD_IN 8'h0E
`define PBCE_IDX_OPTIONS 8'h10
`define PBCE_IDX_STATUS 8'h11
`define PBCE_RESET_DIR 4'h0
`define PBCE_RESET_DATA 4'h0
`define PBCE_RESET_OPTIONS 8'h00
`define PBCE_WAKE_VECTOR 13'h0004
`define PBCE_OPT_AMP 0
`define PBCE_OPT_CMP1 1
`define PBCE_OPT_CMP2 2
`define PBCE_OPT_BIT1_READ_ZERO 3
`define PBCE_OPT_BIT3_READ_ZERO 4
`define PBCE_OPT_GAIN 5
`define PBCE_VARIANT_OUT 2'h0
`define PBCE_VARIANT_IN 2'h1
`define PBCE_VARIANT_BIDIR 2'h2
`endif

// File: pbce_pkg.sv
// Purpose: Types shared by the Port B / third port block.
// Assumes: Constants come from pbce_params.svh.
// Notes: Holds the analog-assist mode type and the state record.
`include "pbce_params.svh"
package pbce_pkg;
   typedef enum logic [1:0] {PBCE_MODE_PLAIN, PBCE_MODE_AMP, PBCE_MODE_DUAL_CMP, PBCE_MODE_CMP_AMP} pbce_mode_e;
   typedef struct packed {
      logic [3:0] pb_dir;
      logic [3:0] pb_latch;
      logic [3:0] third_dir;
      logic [3:0] third_latch;
      logic [7:0] options;
      logic [3:0] pb_in;
      logic [3:0] third_in;
      logic [3:0] pb_prev;
      logic [1:0] cmp_in;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic wake;
      logic [12:0] wake_pc;
      logic wake_seen;
      logic [3:0] pb_out;
      logic [3:0] pb_oe;
      logic [3:0] pb_pd;
      logic [3:0] third_out;
      logic [3:0] third_oe;
      logic [3:0] third_pd;
      logic amp_on;
      logic [1:0] cmp_on;
   } pbce_state_s;
endpackage

// File: pbce_pin_model.sv
// Purpose: Board side of the pins, with the comparators seen as plain levels.
// Assumes: No pull-ups on the board; an undriven pin shows the level the bench sets.
// Notes: A pin the port drives shows the port's own level, as a real wire would.
`timescale 1ns/10ps
module pbce_pin_model (
   input wire logic [3:0] pb_out_in,
   input wire logic [3:0] pb_oe_in,
   input wire logic [3:0] pb_ext_in,
   input wire logic [3:0] th_out_in,
   input wire logic [3:0] th_oe_in,
   input wire logic [3:0] th_ext_in,
   output logic [3:0] pb_wire_out,
   output logic [3:0] th_wire_out
);
   assign pb_wire_out = (pb_out_in & pb_oe_in) | (pb_ext_in & ~pb_oe_in);
   assign th_wire_out = (th_out_in & th_oe_in) | (th_ext_in & ~th_oe_in);
endmodule // pbce_pin_model

// File: tb_top.sv
// Purpose: Self-checking bench for the Port B and third port block.
// Assumes: Bidirectional third port; the slave answers with a pready pulse.
// Notes: Reads are scored from a queue by a separate monitor.
`timescale 1ns/10ps
module tb_top;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, halt = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, wake, amp_en, ca, seen;
   logic [3:0] wake_en = 4'h0, pb_pdo = 4'h0, th_pdo = 4'h0, pb_ext = 4'h0, th_ext = 4'h0;
   logic [3:0] pb_pin, pb_out, pb_oe, pb_pd, th_pin, th_out, th_oe, th_pd, d, l, x;
   logic [1:0] cmp = 2'h0, cmp_en, md;
   logic [12:0] wake_pc;
   logic [7:0] o;
   logic [64:0] expq[$];
   logic [64:0] e;
   logic [7:0] opt_t [8] = '{8'h00, 8'h01, 8'h05, 8'h02, 8'h04, 8'h06, 8'h0B, 8'h14};
   int num_errors = 0, checks = 0, cyc = 0;
   initial forever #20 clk_in = ~clk_in;
   pbce_gpio #(.VARIANT(2'h2)) pbce_gpio_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .halt_in(halt), .wake_enable_in(wake_en),
      .pb_pulldown_opt_in(pb_pdo), .third_pulldown_opt_in(th_pdo), .pb_pin_in(pb_pin),
      .pb_pin_out(pb_out), .pb_pin_oe_out(pb_oe), .pb_pulldown_out(pb_pd), .third_pin_in(th_pin),
      .third_pin_out(th_out), .third_pin_oe_out(th_oe), .third_pulldown_out(th_pd),
      .cmp_result_in(cmp), .amp_enable_out(amp_en), .cmp_enable_out(cmp_en), .wake_out(wake),
      .wake_pc_out(wake_pc));
   pbce_pin_model pbce_pin_model_inst (.pb_out_in(pb_out), .pb_oe_in(pb_oe), .pb_ext_in(pb_ext),
      .th_out_in(th_out), .th_oe_in(th_oe), .th_ext_in(th_ext), .pb_wire_out(pb_pin),
      .th_wire_out(th_pin));
   task automatic finish_test();
      $display("Errors %0d in %0d checks", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [32:0] g, input logic [32:0] w, input string m);
      checks++;
      if (g !== w) begin
         num_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, w);
      end
   endtask
   // Starting on a fresh edge keeps psel from being driven twice in one step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_in);
      pen <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) @(posedge clk_in);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdx(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input logic er);
      expq.push_back({er, m, v & m});
      apb(1'b0, a, 32'h0);
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
      if (psel && pen && !pwr && pready === 1'b1) begin
         e = expq.pop_front();
         check({pslverr, prdata & e[63:32]}, {e[64], e[31:0]}, "read");
      end
   end
   initial begin
      void'($urandom(38));
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      rdx(12'h014, 32'h0, 32'hF, 1'b0);
      rdx(12'h004, 32'h0, 32'hF, 1'b0);
      rdx(12'h010, 32'h0, 32'hF, 1'b0);
      rdx(12'h038, 32'h0, 32'hFFFFFFFF, 1'b1);
      rdx(12'h03C, 32'h0, 32'hFFFFFFFF, 1'b1);
      check({25'h0, pb_oe, th_oe}, 33'h0, "oe reset");
      for (int k = 0; k < 2; k++) begin
         pb_ext <= 4'($urandom);
         th_ext <= 4'($urandom);
         pb_pdo <= 4'($urandom);
         th_pdo <= 4'($urandom);
         l = 4'($urandom);
         d = 4'($urandom);
         apb(1'b1, k ? 12'h010 : 12'h018, {28'h0, l});
         apb(1'b1, k ? 12'h004 : 12'h014, {28'h0, d});
         repeat (4) @(posedge clk_in);
         rdx(k ? 12'h010 : 12'h018, {28'h0, (l & d) | ((k ? th_ext : pb_ext) & ~d)}, 32'hF, 1'b0);
         check({29'h0, k ? th_oe : pb_oe}, {29'h0, d}, "oe");
         check({29'h0, (k ? th_out : pb_out) & d}, {29'h0, l & d}, "out");
         check({29'h0, k ? th_pd : pb_pd}, {29'h0, (k ? th_pdo : pb_pdo) & ~d}, "pull");
         apb(1'b1, k ? 12'h004 : 12'h014, 32'h0);
      end
      // Gain stays off in every entry, and third-port pin 1 stays an input.
      for (int i = 0; i < 8; i++) begin
         o = opt_t[i];
         cmp <= 2'($urandom);
         apb(1'b1, 12'h040, {24'h0, o});
         repeat (4) @(posedge clk_in);
         ca = o[0] & o[1] & !o[2];
         md = ca ? 2'h3 : o[0] ? 2'h1 : (o[1] | o[2]) ? 2'h2 : 2'h0;
         x = {!ca & !o[4] & th_ext[3], ca ? 1'b0 : o[2] ? cmp[1] : th_ext[2], !o[3] & th_ext[1],
            (o[1] && md != 2'h1) ? cmp[0] : th_ext[0]};
         rdx(12'h010, {28'h0, x}, md == 2'h1 ? 32'h0 : 32'hF, 1'b0);
         rdx(12'h044, {26'h0, md, 1'b0, cmp, 1'b0}, 32'h36, 1'b0);
         check({30'h0, amp_en, cmp_en}, {30'h0, o[0], md == 2'h1 ? 2'h0 : {o[2], o[1]}}, "mode");
      end
      wake_en <= 4'h2;
      halt <= 1'b1;
      pb_ext <= 4'h0;
      repeat (4) @(posedge clk_in);
      for (int k = 0; k < 2; k++) begin
         pb_ext <= k ? 4'h3 : 4'h1;
         seen = 1'b0;
         repeat (8) begin
            @(posedge clk_in);
            if (wake === 1'b1) seen = 1'b1;
         end
         check({32'h0, seen}, {32'h0, k[0]}, "wake");
      end
      check({20'h0, wake_pc}, 33'h4, "vector");
      rdx(12'h044, 32'h8, 32'h8, 1'b0);
      apb(1'b1, 12'h044, 32'h8);
      rdx(12'h044, 32'h0, 32'h8, 1'b0);
      halt <= 1'b0;
      repeat (3) @(posedge clk_in);
      finish_test();
   end
endmodule // tb_top
